// file: hw/lcdcd_defines.svh
// Offsets, field positions, reset values and timing counts of the LCD command decoder
`ifndef LCDCD_DEFINES_SVH
`define LCDCD_DEFINES_SVH

// Avalon byte offsets
`define LCDCD_OFF_CMD 4'h0
`define LCDCD_OFF_DATA 4'h4
`define LCDCD_OFF_MODE 4'h8
`define LCDCD_OFF_LEVEL 4'hC

// Display RAM geometry
`define LCDCD_PAGES 9
`define LCDCD_COLS 132
`define LCDCD_ROWS 65
`define LCDCD_RAM_WORDS 1188

// Status byte field positions
`define LCDCD_ST_BUSY 7
`define LCDCD_ST_SEGREV 6
`define LCDCD_ST_ON 5
`define LCDCD_ST_RMW 4

// Reset values of the command registers
`define LCDCD_RST_START 6'h00
`define LCDCD_RST_PAGE 4'h0
`define LCDCD_RST_COL 8'h00
`define LCDCD_RST_POWER 3'h0
`define LCDCD_RST_VOLUME 5'h00

// Frame timing in master mode, in clock cycles
`define LCDCD_FRAME_CYCLES 12'hFA0

`endif

// file: hw/lcdcd_pkg.sv
// Types shared by the LCD command decoder
`default_nettype none
package lcdcd_pkg;

    // Decoded command kinds
    typedef enum logic [4:0] {
        LCDCD_NONE, LCDCD_ONOFF, LCDCD_START, LCDCD_PAGE, LCDCD_COL_HI,
        LCDCD_COL_LO, LCDCD_SEGDIR, LCDCD_INVERT, LCDCD_ALLON, LCDCD_BIAS,
        LCDCD_RMW, LCDCD_RMW_END, LCDCD_RESET, LCDCD_COMDIR, LCDCD_POWER,
        LCDCD_VOLUME, LCDCD_STANDBY
    } lcdcd_cmd_t;

    // Display settings driven out of the block
    typedef struct packed {
        logic display_on;
        logic [5:0] start_line;
        logic seg_reverse;
        logic com_reverse;
        logic invert;
        logic all_on;
        logic bias;
        logic [2:0] power_mode;
        logic [4:0] volume;
        logic standby;
        logic power_save;
    } lcdcd_disp_t;

endpackage : lcdcd_pkg
`default_nettype wire

// file: hw/lcdcd_top.sv
// LCD command decoder with display RAM behind an Avalon-MM slave
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcdcd_defines.svh"

module lcdcd_top
    import lcdcd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic i_avs_chipselect,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Display scan port
    input wire logic [6:0] i_scan_row,
    input wire logic [7:0] i_scan_seg,
    output logic o_scan_pixel,
    // Display settings
    output lcdcd_disp_t o_disp,
    // Frame timing pins
    input wire logic i_master,
    output logic o_frame_polarity,
    output logic o_frame_polarity_oe,
    output logic o_display_timing_out,
    output logic o_display_timing_out_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte code to command kind; unknown codes decode to none
    function automatic lcdcd_cmd_t decode(input logic [7:0] c);
        lcdcd_cmd_t k;
        k = LCDCD_NONE;
        if (c[7:1] == 7'h57) begin
            k = LCDCD_ONOFF;
        end else if (c[7:1] == 7'h50) begin
            k = LCDCD_SEGDIR;
        end else if (c[7:1] == 7'h53) begin
            k = LCDCD_INVERT;
        end else if (c[7:1] == 7'h52) begin
            k = LCDCD_ALLON;
        end else if (c[7:1] == 7'h51) begin
            k = LCDCD_BIAS;
        end else if (c[7:1] == 7'h56) begin
            k = LCDCD_STANDBY;
        end else if (c == 8'hE0) begin
            k = LCDCD_RMW;
        end else if (c == 8'hEE) begin
            k = LCDCD_RMW_END;
        end else if (c == 8'hE2) begin
            k = LCDCD_RESET;
        end else if (c[7:6] == 2'h1) begin
            k = LCDCD_START;
        end else if (c[7:4] == 4'hB) begin
            k = LCDCD_PAGE;
        end else if (c[7:4] == 4'h1) begin
            k = LCDCD_COL_HI;
        end else if (c[7:4] == 4'h0) begin
            k = LCDCD_COL_LO;
        end else if (c[7:4] == 4'hC) begin
            k = LCDCD_COMDIR;
        end else if (c[7:3] == 5'h05) begin
            k = LCDCD_POWER;
        end else if (c[7:5] == 3'h4) begin
            k = LCDCD_VOLUME;
        end
        return k;
    endfunction : decode

    // True when page and column lie inside the RAM
    function automatic logic in_ram(input logic [3:0] p, input logic [7:0] c);
        return (p < 4'(`LCDCD_PAGES)) && (c < 8'(`LCDCD_COLS));
    endfunction : in_ram

    // Flat RAM index of a page and column
    function automatic logic [10:0] ram_idx(input logic [3:0] p, input logic [7:0] c);
        return 11'(p * `LCDCD_COLS) + 11'(c);
    endfunction : ram_idx

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    logic ack;
    logic req;
    logic done;
    logic wr_go;
    logic rd_go;
    logic cmd_go;
    logic dat_wr;
    logic dat_rd;
    lcdcd_cmd_t kind;
    logic [7:0] wbyte;

    // Every access waits one cycle so read data can come from a flop
    assign req = i_avs_chipselect && (i_avs_read || i_avs_write);
    assign o_avs_waitrequest = req && !ack;
    assign done = req && ack;
    assign wr_go = done && i_avs_write && i_avs_byteenable[0];
    assign rd_go = done && i_avs_read;
    assign wbyte = i_avs_writedata[7:0];
    assign cmd_go = wr_go && (i_avs_address == `LCDCD_OFF_CMD);
    assign dat_wr = wr_go && (i_avs_address == `LCDCD_OFF_DATA);
    assign dat_rd = rd_go && (i_avs_address == `LCDCD_OFF_DATA);
    // Undefined codes are dropped rather than trusted
    assign kind = cmd_go ? decode(wbyte) : LCDCD_NONE;

    // Acknowledge flop
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command registers

    logic [3:0] page;
    logic [7:0] col;
    logic rmw;
    logic col_step;

    // Reads advance the column only outside read/modify/write
    assign col_step = dat_wr || (dat_rd && !rmw);

    // Display settings, soft reset keeps RAM untouched
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_disp <= '0;
        end else begin
            case (kind)
                LCDCD_RESET: begin
                    o_disp <= '0;
                end
                LCDCD_ONOFF: begin
                    o_disp.display_on <= wbyte[0];
                end
                LCDCD_START: begin
                    o_disp.start_line <= wbyte[5:0];
                end
                LCDCD_SEGDIR: begin
                    o_disp.seg_reverse <= wbyte[0];
                end
                LCDCD_INVERT: begin
                    o_disp.invert <= wbyte[0];
                end
                LCDCD_ALLON: begin
                    o_disp.all_on <= wbyte[0];
                end
                LCDCD_BIAS: begin
                    o_disp.bias <= wbyte[0];
                end
                LCDCD_COMDIR: begin
                    o_disp.com_reverse <= wbyte[3];
                end
                LCDCD_POWER: begin
                    o_disp.power_mode <= wbyte[2:0];
                end
                LCDCD_VOLUME: begin
                    o_disp.volume <= wbyte[4:0];
                end
                LCDCD_STANDBY: begin
                    o_disp.standby <= wbyte[0];
                end
                default: begin
                    o_disp <= o_disp;
                end
            endcase
            // Composite of display off and all pixels on
            o_disp.power_save <= 1'b0;
            if (kind != LCDCD_RESET) begin
                o_disp.power_save <= !o_disp.display_on && o_disp.all_on;
            end
        end
    end

    // Page and column counters
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page <= `LCDCD_RST_PAGE;
            col <= `LCDCD_RST_COL;
        end else if (kind == LCDCD_RESET) begin
            page <= `LCDCD_RST_PAGE;
            col <= `LCDCD_RST_COL;
        end else if (kind == LCDCD_PAGE) begin
            page <= wbyte[3:0];
        end else if (kind == LCDCD_COL_HI) begin
            col[7:4] <= wbyte[3:0];
        end else if (kind == LCDCD_COL_LO) begin
            col[3:0] <= wbyte[3:0];
        end else if (col_step && (col < 8'(`LCDCD_COLS - 1))) begin
            col <= col + 8'h01; // Stops at the last column
        end
    end

    // Read/modify/write mode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rmw <= 1'b0;
        end else if (kind == LCDCD_RMW) begin
            rmw <= 1'b1;
        end else if ((kind == LCDCD_RMW_END) || (kind == LCDCD_RESET)) begin
            rmw <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display RAM

    logic [7:0] ram [`LCDCD_RAM_WORDS];

    // No reset: contents survive both resets, as a real RAM would
    always_ff @(posedge i_clk) begin
        if (dat_wr && in_ram(page, col)) begin
            ram[ram_idx(page, col)] <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [7:0] status;
    logic [7:0] ram_q;
    logic [31:0] next_rdata;

    // Status flags in the high nibble, low nibble zero
    assign status = {1'b0, o_disp.seg_reverse, o_disp.display_on, rmw, 4'h0};
    assign ram_q = in_ram(page, col) ? ram[ram_idx(page, col)] : 8'h00;

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_avs_address == `LCDCD_OFF_CMD) begin
            next_rdata = {24'h00_0000, status};
        end else if (i_avs_address == `LCDCD_OFF_DATA) begin
            next_rdata = {24'h00_0000, ram_q};
        end else if (i_avs_address == `LCDCD_OFF_MODE) begin
            next_rdata = {16'h0000, o_disp.standby, o_disp.power_save,
                          o_disp.bias, o_disp.all_on, o_disp.invert,
                          o_disp.com_reverse, o_disp.seg_reverse,
                          o_disp.display_on, 2'h0, o_disp.start_line};
        end else if (i_avs_address == `LCDCD_OFF_LEVEL) begin
            next_rdata = {16'h0000, 1'b0, rmw, 3'h0, o_disp.power_mode,
                          3'h0, o_disp.volume};
        end
    end

    // Data captured in the wait cycle, held through the answer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (req && !ack && i_avs_read) begin
            o_avs_readdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan port

    logic [6:0] row_m;
    logic [7:0] line_sum;
    logic [6:0] line;
    logic [7:0] seg_m;
    logic [7:0] scan_byte;
    logic scan_bit;

    // Common reversal first, then start line offset modulo the row count
    assign row_m = o_disp.com_reverse ? 7'(`LCDCD_ROWS - 1) - i_scan_row : i_scan_row;
    assign line_sum = {1'b0, row_m} + {2'h0, o_disp.start_line};
    assign line = (line_sum >= 8'(`LCDCD_ROWS)) ? 7'(line_sum - 8'(`LCDCD_ROWS))
                                                 : line_sum[6:0];
    assign seg_m = o_disp.seg_reverse ? 8'(`LCDCD_COLS - 1) - i_scan_seg : i_scan_seg;
    assign scan_byte = in_ram(line[6:3], seg_m)
                       ? ram[ram_idx(line[6:3], seg_m)] : 8'h00;
    assign scan_bit = scan_byte[line[2:0]];

    // Pixel after display modes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_scan_pixel <= 1'b0;
        end else if (!o_disp.display_on || o_disp.standby) begin
            o_scan_pixel <= 1'b0;
        end else if (o_disp.all_on) begin
            o_scan_pixel <= 1'b1;
        end else begin
            o_scan_pixel <= scan_bit ^ o_disp.invert;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame timing

    logic [11:0] frame_cnt;
    logic frame_end;

    assign frame_end = frame_cnt == 12'(`LCDCD_FRAME_CYCLES - 1);
    // Pins only driven as master; a slave takes timing from elsewhere
    assign o_frame_polarity_oe = i_master;
    assign o_display_timing_out_oe = i_master;

    // Frame counter, polarity toggle and frame-start pulse
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_cnt <= 12'h000;
            o_frame_polarity <= 1'b0;
            o_display_timing_out <= 1'b0;
        end else if (!i_master) begin
            frame_cnt <= 12'h000;
            o_frame_polarity <= 1'b0;
            o_display_timing_out <= 1'b0;
        end else begin
            frame_cnt <= frame_end ? 12'h000 : frame_cnt + 12'h001;
            o_frame_polarity <= o_frame_polarity ^ frame_end;
            o_display_timing_out <= frame_end;
        end
    end

endmodule : lcdcd_top
`default_nettype wire

// file: tb/lcdcd_checker.sv
// Concurrent checks on the ports of the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module lcdcd_checker
    import lcdcd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Bus
    input wire logic i_avs_chipselect,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Settings and frame pins
    input wire lcdcd_disp_t o_disp,
    input wire logic i_master,
    input wire logic o_frame_polarity,
    input wire logic o_frame_polarity_oe,
    input wire logic o_display_timing_out
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Command byte taken at the edge that ends a write to the command offset
    logic cmd_fire;
    logic [7:0] cmd;
    assign cmd_fire = i_avs_chipselect && i_avs_write && !o_avs_waitrequest
        && i_avs_address == 4'h0 && i_avs_byteenable[0];
    assign cmd = i_avs_writedata[7:0];
    sequence cmd_s(logic [7:0] mask, logic [7:0] code);
        cmd_fire && ((cmd & mask) == code);
    endsequence
    sequence stat_s;
        i_avs_chipselect && i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h0;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // Settings follow the command one cycle after the accepting edge
    disp_onoff_a: assert property (
        cmd_s(8'hFE, 8'hAE) |=> o_disp.display_on == $past(cmd[0])) else $error("display on bad");
    start_line_a: assert property (
        cmd_s(8'hC0, 8'h40) |=> o_disp.start_line == $past(cmd[5:0])) else $error("start bad");
    seg_dir_a: assert property (
        cmd_s(8'hFE, 8'hA0) |=> o_disp.seg_reverse == $past(cmd[0])) else $error("seg dir bad");
    invert_mode_a: assert property (
        cmd_s(8'hFE, 8'hA6) |=> o_disp.invert == $past(cmd[0])) else $error("invert bad");
    volume_load_a: assert property (
        cmd_s(8'hE0, 8'h80) |=> o_disp.volume == $past(cmd[4:0])) else $error("volume bad");
    power_mode_a: assert property (
        cmd_s(8'hF8, 8'h28) |=> o_disp.power_mode == $past(cmd[2:0])) else $error("power bad");
    // Power save lags its two causes by one cycle; soft reset may clear it early
    power_save_a: assert property (
        o_disp.power_save != $past(!o_disp.display_on && o_disp.all_on)
        |-> $past(cmd_fire && cmd == 8'hE2)) else $error("power save bad");
    status_read_a: assert property (
        stat_s |-> o_avs_readdata[3:0] == 4'h0 && o_avs_readdata[5] == o_disp.display_on)
        else $error("status bad");
    // Frame pins stay quiet in slave mode
    slave_quiet_a: assert property (
        !i_master && $past(!i_master) |-> !o_frame_polarity_oe && !o_frame_polarity
        && !o_display_timing_out) else $error("slave frame pins driven");
endmodule : lcdcd_checker
bind lcdcd_top lcdcd_checker chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_avs_chipselect(i_avs_chipselect), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_disp(o_disp), .i_master(i_master),
    .o_frame_polarity(o_frame_polarity), .o_frame_polarity_oe(o_frame_polarity_oe),
    .o_display_timing_out(o_display_timing_out));
`default_nettype wire

// file: tb/lcdcd_host.sv
// Host processor model acting as Avalon-MM master
`timescale 1ns/1ps
`default_nettype none
module lcdcd_host (
    // Clock
    input wire logic i_clk,
    // Answer
    input wire logic [31:0] i_readdata,
    input wire logic i_waitrequest,
    // Request
    output logic o_cs,
    output logic [3:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [31:0] o_wdata
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        o_cs = 1'b0;
        o_addr = 4'h0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 32'h0;
    end
    // One access; an idle edge after release keeps strobes from toggling twice
    task automatic access(input logic [3:0] a, input logic w, input logic [7:0] d,
                          output logic [7:0] q);
        o_cs <= 1'b1; // Each device is selected on its own
        o_addr <= a;
        o_wr <= w;
        o_rd <= !w;
        o_wdata <= {24'h0, d}; // Callers pass only defined codes
        @(posedge i_clk);
        while (i_waitrequest !== 1'b0) begin
            @(posedge i_clk);
        end
        q = i_readdata[7:0];
        o_cs <= 1'b0;
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        @(posedge i_clk);
    endtask : access
endmodule : lcdcd_host
`default_nettype wire

// file: tb/lcdcd_top_tb_top.sv
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module lcdcd_top_tb_top;
    import lcdcd_pkg::*;
    logic clk;
    logic rst_n;
    logic cs;
    logic [3:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wreq;
    logic [6:0] row;
    logic [7:0] seg;
    logic pixel;
    logic master;
    logic fpol;
    logic fpol_oe;
    logic dto;
    logic dto_oe;
    lcdcd_disp_t disp;
    lcdcd_disp_t exp_disp;
    int err_count;
    int cmp_count;
    int cyc = 0;
    int n;
    ////////////////////////////////////////////////////////////////////////////////
    lcdcd_host host_u (.i_clk(clk), .i_readdata(rdata), .i_waitrequest(wreq), .o_cs(cs),
        .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
    lcdcd_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_avs_chipselect(cs), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'h1), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_scan_row(row), .i_scan_seg(seg),
        .o_scan_pixel(pixel), .o_disp(disp), .i_master(master), .o_frame_polarity(fpol),
        .o_frame_polarity_oe(fpol_oe), .o_display_timing_out(dto),
        .o_display_timing_out_oe(dto_oe));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] c);
        logic [7:0] q;
        host_u.access(4'h0, 1'b1, c, q);
    endtask : cmd
    task automatic dwr(input logic [7:0] d);
        logic [7:0] q;
        host_u.access(4'h4, 1'b1, d, q);
    endtask : dwr
    task automatic rdc(input logic [3:0] a, input string nm, input logic [7:0] e);
        logic [7:0] q;
        host_u.access(a, 1'b0, 8'h00, q);
        chk(nm, {24'h0, e}, {24'h0, q});
    endtask : rdc
    // Pixel query has one cycle of latency
    task automatic pix(input logic [6:0] r, input logic [7:0] s, input logic e);
        row <= r;
        seg <= s;
        repeat (2) @(posedge clk);
        chk("pixel", {31'h0, e}, {31'h0, pixel});
    endtask : pix
    // Hang guard: the sequence needs about 8200 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        row = 7'h00;
        seg = 8'h00;
        master = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(4'h0, "status", 8'h00);
        cmd(8'hAF);
        rdc(4'h0, "status", 8'h20);
        // Page 1, column 5: two bytes, then read back with auto increment
        cmd(8'hB1);
        cmd(8'h10);
        cmd(8'h05);
        dwr(8'hA5);
        dwr(8'h3C);
        cmd(8'h05);
        rdc(4'h4, "ram", 8'hA5);
        rdc(4'h4, "ram", 8'h3C);
        // Read/modify/write: read holds column, write advances it
        cmd(8'h05);
        cmd(8'hE0);
        rdc(4'h0, "status", 8'h30);
        rdc(4'h4, "ram", 8'hA5);
        dwr(8'h11);
        rdc(4'h4, "ram", 8'h3C);
        cmd(8'hEE);
        cmd(8'h05);
        rdc(4'h4, "ram", 8'h11);
        rdc(4'h4, "ram", 8'h3C);
        // Scan path: one lit pixel at page 0, column 0
        cmd(8'hB0);
        cmd(8'h00);
        dwr(8'h01);
        pix(7'd0, 8'd0, 1'b1);
        cmd(8'hA7);
        pix(7'd0, 8'd0, 1'b0);
        cmd(8'hA6);
        cmd(8'hA1);
        pix(7'd0, 8'd131, 1'b1);
        cmd(8'hA0);
        cmd(8'hA5);
        pix(7'd1, 8'd0, 1'b1);
        cmd(8'hAE);
        @(posedge clk);
        chk("power_save", 32'h1, {31'h0, disp.power_save});
        pix(7'd1, 8'd0, 1'b0);
        cmd(8'hAF);
        cmd(8'hA4);
        pix(7'd1, 8'd0, 1'b0);
        // Remaining settings, then standby blanks the panel
        cmd(8'h7F);
        cmd(8'hC8);
        cmd(8'hA3);
        cmd(8'h2D);
        cmd(8'h93);
        cmd(8'hAD);
        exp_disp = '0;
        exp_disp.display_on = 1'b1;
        exp_disp.start_line = 6'h3F;
        exp_disp.com_reverse = 1'b1;
        exp_disp.bias = 1'b1;
        exp_disp.power_mode = 3'h5;
        exp_disp.volume = 5'h13;
        exp_disp.standby = 1'b1;
        chk("settings", {10'h0, exp_disp}, {10'h0, disp});
        pix(7'd0, 8'd0, 1'b0);
        rdc(4'h8, "mode", 8'h3F);
        rdc(4'hC, "level", 8'h13);
        // Soft reset keeps RAM and returns page and column to zero
        cmd(8'hE2);
        chk("settings", 32'h0, {10'h0, disp});
        rdc(4'h4, "ram", 8'h01);
        rdc(4'h2, "unmapped", 8'h00);
        chk("timing oe", 32'h0, {31'h0, dto_oe});
        // Master mode frame period between timing pulses
        master <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dto !== 1'b1 && n < 4100);
        chk("polarity", 32'h1, {31'h0, fpol});
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dto !== 1'b1 && n < 4100);
        chk("frame period", 32'd4000, n);
        chk("polarity oe", 32'h1, {31'h0, fpol_oe});
        chk("polarity", 32'h0, {31'h0, fpol});
        chk("timing oe", 32'h1, {31'h0, dto_oe});
        wrap_up();
    end
endmodule : lcdcd_top_tb_top
`default_nettype wire
